/* File: design/dcmc_pkg.sv */
// package of constants for the dual clock mode control block
// Overview of operation
// - fast oscillator: internal fast rc, fast crystal or mid crystal
// - internal fast rc frequency 1, 2, 4, 8, 16 or 20 mhz by three words
// - with internal fast rc and internal slow rc pads are gpio; pad seven may give inst clock
// - any crystal mode dedicates pad six as crystal in, pad seven as out
// - a word picks slow source: internal slow rc or 32768 hz slow crystal
// - only four fast and slow source pairings are supported
// - system clock is fast oscillator when select bit is 1, else slow
// - instruction clock is system clock divided by 2 or by 4
// - after reset start in normal or slow mode per startup clock word
// - normal mode runs on fast oscillator; slow oscillator keeps running
// - writing power mode field at bits 3:2 enters standby or halt
// - power mode field 10b is standby, 01b is halt
// - standby stops all but timers 0, 1, 4 and watchdog
// - halt sleeps until an external event or watchdog wakes it
// - in normal mode timer 0 uses slow clock when both selects are 1
package dcmc_pkg;
    typedef enum logic [1:0] {DCMC_FAST_IRC, DCMC_FAST_HXT, DCMC_FAST_XT,
        DCMC_FAST_BAD} dcmc_fast_src_t;
    typedef enum logic [2:0] {DCMC_F1M, DCMC_F2M, DCMC_F4M, DCMC_F8M,
        DCMC_F16M, DCMC_F20M, DCMC_F_R6, DCMC_F_R7} dcmc_irc_freq_t;
    typedef enum {DCMC_NORMAL, DCMC_SLOW, DCMC_STANDBY,
        DCMC_HALT} dcmc_mode_t;
    localparam int CTRL_SEL_BIT = 0;
    localparam int CTRL_STOP_BIT = 1;
    localparam int CTRL_PMODE_LSB = 2;
    localparam int CTRL_PMODE_MSB = 3;
    localparam logic [1:0] PMODE_STANDBY = 2'h2;
    localparam logic [1:0] PMODE_HALT = 2'h1;
    localparam logic [1:0] PMODE_NONE = 2'h0;
    localparam logic [3:0] CTRL_RESET = 4'h1;
    localparam int SYNC_STAGES = 2;
    localparam int CORE_CLK_HZ = 20000000;
    localparam int SLOW_OSC_HZ = 32768;
endpackage

/* File: design/dcmc_glitch_free_mux.sv */
// glitch free clock select built from per-source handshakes
`timescale 1ns/10ps
`default_nettype none
module dcmc_glitch_free_mux (
    // clocks and reset
    input wire logic clk_a,
    input wire logic clk_b,
    input wire logic reset,
    // select, 1 picks clk_a
    input wire logic sel_a,
    // output
    output logic clk_out,
    output logic a_on,
    output logic b_on
);
    logic a_s1_q;
    logic a_s2_q;
    logic b_s1_q;
    logic b_s2_q;
    logic a_en_q;
    logic b_en_q;

    // a side opens only once the other is shut, on its own falling edge
    always_ff @(negedge clk_a or posedge reset)
    begin
        if (reset)
        begin
            a_s1_q <= 1'b0;
            a_s2_q <= 1'b0;
            a_en_q <= 1'b0;
        end
        else
        begin
            a_s1_q <= sel_a & ~b_en_q;
            a_s2_q <= a_s1_q;
            a_en_q <= a_s2_q;
        end
    end

    always_ff @(negedge clk_b or posedge reset)
    begin
        if (reset)
        begin
            b_s1_q <= 1'b0;
            b_s2_q <= 1'b0;
            b_en_q <= 1'b0;
        end
        else
        begin
            b_s1_q <= ~sel_a & ~a_en_q;
            b_s2_q <= b_s1_q;
            b_en_q <= b_s2_q;
        end
    end

    assign clk_out = (clk_a & a_en_q) | (clk_b & b_en_q);
    assign a_on = a_en_q;
    assign b_on = b_en_q;
endmodule
`default_nettype wire

/* File: design/dcmc_top.sv */
// clock source selection and operating mode control
`timescale 1ns/10ps
`default_nettype none
module dcmc_top (
    // clock and reset
    input wire logic core_clk,
    input wire logic reset,
    // configuration words
    input wire logic [1:0] cfg_fast_src,
    input wire logic [2:0] cfg_irc_freq,
    input wire logic cfg_slow_xtal,
    input wire logic cfg_startup_fast,
    input wire logic cfg_inst_div4,
    input wire logic cfg_inst_clk_out,
    input wire logic cfg_timer0_src,
    // oscillator sources
    input wire logic irc_clk,
    input wire logic fast_xtal_clk,
    input wire logic slow_rc_clk,
    input wire logic slow_xtal_clk,
    // control register write port
    input wire logic ctrl_we,
    input wire logic [3:0] ctrl_wdata,
    input wire logic slow_clock_to_timer_select,
    // wake events
    input wire logic wake_timer,
    input wire logic wake_external,
    input wire logic wake_watchdog,
    // status
    output logic [3:0] ctrl_rdata,
    output logic fast_clock_select,
    output logic [1:0] mode,
    output logic [2:0] irc_freq_sel,
    output logic config_error,
    output logic core_run,
    output logic periph_run,
    output logic timer_run,
    output logic fast_osc_en,
    output logic slow_osc_en,
    output logic timer0_slow_src,
    // clocks
    output logic system_osc_clk,
    output logic instruction_clk,
    output logic fast_on,
    output logic slow_on,
    // pads
    output logic pad_six_is_xin,
    output logic pad_seven_is_xout,
    output logic pad_gpio_free,
    output logic pad_seven_inst_clk
);
    dcmc_pkg::dcmc_mode_t mode_q;
    dcmc_pkg::dcmc_mode_t mode_d;
    logic sel_q;
    logic sel_d;
    logic stop_q;
    logic [1:0] pm_d;
    logic boot_q;
    logic [1:0] div_q;
    logic [1:0] wt_s;
    logic [1:0] we_s;
    logic [1:0] ww_s;
    logic err_q;
    logic xin_q;
    logic xout_q;
    logic gpio_q;
    logic pinst_q;
    logic t0_q;
    logic [2:0] freq_q;
    logic fast_osc_clk;
    logic slow_osc_clk;
    logic mux_fast_on;
    logic mux_slow_on;
    logic fast_xtal_mode;
    logic any_xtal;
    logic pair_ok;
    logic wake_stby;
    logic wake_halt;

    assign fast_xtal_mode = cfg_fast_src == dcmc_pkg::DCMC_FAST_HXT
        || cfg_fast_src == dcmc_pkg::DCMC_FAST_XT;
    assign any_xtal = fast_xtal_mode | cfg_slow_xtal;
    assign pair_ok = cfg_fast_src != dcmc_pkg::DCMC_FAST_BAD
        && cfg_irc_freq <= 3'(dcmc_pkg::DCMC_F20M)
        && !(fast_xtal_mode && cfg_slow_xtal);
    assign fast_osc_clk = fast_xtal_mode ? fast_xtal_clk : irc_clk;
    assign slow_osc_clk = cfg_slow_xtal ? slow_xtal_clk : slow_rc_clk;

    dcmc_glitch_free_mux u_mux (
        .clk_a(fast_osc_clk),
        .clk_b(slow_osc_clk),
        .reset(reset),
        .sel_a(sel_q),
        .clk_out(system_osc_clk),
        .a_on(mux_fast_on),
        .b_on(mux_slow_on)
    );

    // instruction clock divider on the selected system clock
    always_ff @(posedge system_osc_clk or posedge reset)
    begin
        if (reset)
            div_q <= 2'h0;
        else
            div_q <= div_q + 2'h1;
    end
    assign instruction_clk = cfg_inst_div4 ? div_q[1] : div_q[0];

    // wake inputs come from other domains
    always_ff @(posedge core_clk or posedge reset)
    begin
        if (reset)
        begin
            wt_s <= 2'h0;
            we_s <= 2'h0;
            ww_s <= 2'h0;
        end
        else
        begin
            wt_s <= {wt_s[0], wake_timer};
            we_s <= {we_s[0], wake_external};
            ww_s <= {ww_s[0], wake_watchdog};
        end
    end
    assign wake_stby = wt_s[1] | we_s[1] | ww_s[1];
    assign wake_halt = we_s[1] | ww_s[1];

    assign pm_d =
        ctrl_wdata[dcmc_pkg::CTRL_PMODE_MSB:dcmc_pkg::CTRL_PMODE_LSB];
    assign sel_d = boot_q ? cfg_startup_fast
        : (ctrl_we ? ctrl_wdata[dcmc_pkg::CTRL_SEL_BIT] : sel_q);

    always_comb
    begin
        mode_d = mode_q;
        case (mode_q)
            dcmc_pkg::DCMC_NORMAL, dcmc_pkg::DCMC_SLOW:
            begin
                if (ctrl_we && pm_d == dcmc_pkg::PMODE_STANDBY)
                    mode_d = dcmc_pkg::DCMC_STANDBY;
                else if (ctrl_we && pm_d == dcmc_pkg::PMODE_HALT)
                    mode_d = dcmc_pkg::DCMC_HALT;
                else
                    mode_d = sel_d ? dcmc_pkg::DCMC_NORMAL
                        : dcmc_pkg::DCMC_SLOW;
            end
            dcmc_pkg::DCMC_STANDBY:
            begin
                if (wake_stby)
                    mode_d = sel_q ? dcmc_pkg::DCMC_NORMAL
                        : dcmc_pkg::DCMC_SLOW;
            end
            dcmc_pkg::DCMC_HALT:
            begin
                if (wake_halt)
                    mode_d = sel_q ? dcmc_pkg::DCMC_NORMAL
                        : dcmc_pkg::DCMC_SLOW;
            end
            default:
                mode_d = dcmc_pkg::DCMC_NORMAL;
        endcase
        if (boot_q)
            mode_d = cfg_startup_fast ? dcmc_pkg::DCMC_NORMAL
                : dcmc_pkg::DCMC_SLOW;
    end

    always_ff @(posedge core_clk or posedge reset)
    begin
        if (reset)
        begin
            boot_q <= 1'b1;
            mode_q <= dcmc_pkg::DCMC_NORMAL;
            sel_q <= dcmc_pkg::CTRL_RESET[dcmc_pkg::CTRL_SEL_BIT];
            stop_q <= dcmc_pkg::CTRL_RESET[dcmc_pkg::CTRL_STOP_BIT];
        end
        else
        begin
            boot_q <= 1'b0;
            mode_q <= mode_d;
            sel_q <= sel_d;
            if (boot_q)
                stop_q <= 1'b0;
            else if (ctrl_we)
                stop_q <= ctrl_wdata[dcmc_pkg::CTRL_STOP_BIT];
        end
    end

    // registered pad and status decode
    always_ff @(posedge core_clk or posedge reset)
    begin
        if (reset)
        begin
            err_q <= 1'b0;
            xin_q <= 1'b0;
            xout_q <= 1'b0;
            gpio_q <= 1'b0;
            pinst_q <= 1'b0;
            t0_q <= 1'b0;
            freq_q <= 3'h0;
        end
        else
        begin
            err_q <= ~pair_ok;
            xin_q <= any_xtal;
            xout_q <= any_xtal;
            gpio_q <= ~any_xtal;
            pinst_q <= ~any_xtal & cfg_inst_clk_out;
            // no timer source pulse while the startup mode is still loading
            t0_q <= !boot_q && mode_q == dcmc_pkg::DCMC_NORMAL
                && slow_clock_to_timer_select && cfg_timer0_src;
            freq_q <= cfg_fast_src == dcmc_pkg::DCMC_FAST_IRC
                ? cfg_irc_freq : 3'h0;
        end
    end

    assign ctrl_rdata = {mode_q == dcmc_pkg::DCMC_STANDBY,
        mode_q == dcmc_pkg::DCMC_HALT, stop_q, sel_q};
    assign fast_clock_select = sel_q;
    assign mode = 2'(mode_q);
    assign irc_freq_sel = freq_q;
    assign config_error = err_q;
    assign core_run = mode_q == dcmc_pkg::DCMC_NORMAL
        || mode_q == dcmc_pkg::DCMC_SLOW;
    assign periph_run = core_run;
    assign timer_run = mode_q != dcmc_pkg::DCMC_HALT;
    assign fast_osc_en = mode_q == dcmc_pkg::DCMC_NORMAL
        || (mode_q != dcmc_pkg::DCMC_HALT && !stop_q);
    assign slow_osc_en = mode_q != dcmc_pkg::DCMC_HALT;
    assign timer0_slow_src = t0_q;
    assign fast_on = mux_fast_on;
    assign slow_on = mux_slow_on;
    assign pad_six_is_xin = xin_q;
    assign pad_seven_is_xout = xout_q;
    assign pad_gpio_free = gpio_q;
    assign pad_seven_inst_clk = pinst_q;

    a_halt_wake_only: assert property (@(posedge core_clk) disable iff (reset)
        mode_q == dcmc_pkg::DCMC_HALT && !wake_halt && !boot_q
        |=> mode_q == dcmc_pkg::DCMC_HALT)
        else $error("halt left without wake");
    a_standby_enter: assert property (@(posedge core_clk) disable iff (reset)
        !boot_q && core_run && ctrl_we && pm_d == dcmc_pkg::PMODE_STANDBY
        |=> mode_q == dcmc_pkg::DCMC_STANDBY)
        else $error("standby not entered");
    a_halt_enter: assert property (@(posedge core_clk) disable iff (reset)
        !boot_q && core_run && ctrl_we && pm_d == dcmc_pkg::PMODE_HALT
        |=> mode_q == dcmc_pkg::DCMC_HALT)
        else $error("halt not entered");
    a_slow_write: assert property (@(posedge core_clk) disable iff (reset)
        !boot_q && core_run && ctrl_we && pm_d == dcmc_pkg::PMODE_NONE
        && !ctrl_wdata[0] |=> mode_q == dcmc_pkg::DCMC_SLOW && !sel_q)
        else $error("slow mode not entered");
    a_startup_mode: assert property (@(posedge core_clk) disable iff (reset)
        boot_q |=> sel_q == $past(cfg_startup_fast))
        else $error("startup select wrong");
    a_pads_xtal: assert property (@(posedge core_clk) disable iff (reset)
        any_xtal ##1 $stable(any_xtal) |-> pad_six_is_xin && !pad_gpio_free
        && !pad_seven_inst_clk)
        else $error("crystal pads still gpio");
    a_timer0_src: assert property (@(posedge core_clk) disable iff (reset)
        timer0_slow_src |-> $past(mode_q == dcmc_pkg::DCMC_NORMAL))
        else $error("timer0 slow source outside normal");
    a_pair_error: assert property (@(posedge core_clk) disable iff (reset)
        fast_xtal_mode && cfg_slow_xtal |=> config_error)
        else $error("bad pairing not flagged");
    a_mux_exclusive: assert property (@(posedge core_clk) disable iff (reset)
        !(mux_fast_on && mux_slow_on))
        else $error("both clock gates open");
endmodule
`default_nettype wire

/* File: tb/dcmc_osc_model.sv */
// free running oscillator and crystal sources
`timescale 1ns/10ps
`default_nettype none
module dcmc_osc_model #(
    parameter real FAST_HALF = 30.0,
    parameter real SLOW_HALF = 15258.8
) (
    // oscillator outputs
    output logic irc_clk,
    output logic fast_xtal_clk,
    output logic slow_rc_clk,
    output logic slow_xtal_clk
);
    initial
    begin
        irc_clk = 1'b0;
        fast_xtal_clk = 1'b0;
        slow_rc_clk = 1'b0;
        slow_xtal_clk = 1'b1;
    end
    always #(FAST_HALF) irc_clk = ~irc_clk;
    always #(FAST_HALF + 7.0) fast_xtal_clk = ~fast_xtal_clk;
    always #(SLOW_HALF) slow_rc_clk = ~slow_rc_clk;
    // crystal only runs at 32768 hz
    always #(SLOW_HALF) slow_xtal_clk = ~slow_xtal_clk;
endmodule
`default_nettype wire

/* File: tb/tb_dual_clock_mode_control.sv */
// self-checking bench for the clock and mode control block
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, g) begin check_count++; if ((e) !== (g)) begin n_fail++; \
    $display("mismatch %s exp %0h got %0h", n, e, g); end end
module tb_dual_clock_mode_control;
    logic core_clk, reset, cfg_slow_xtal, cfg_startup_fast, cfg_inst_div4;
    logic cfg_inst_clk_out, cfg_timer0_src, ctrl_we, slow_clock_to_timer_select;
    logic wake_timer, wake_external, wake_watchdog, fast_clock_select;
    logic [1:0] cfg_fast_src, mode;
    logic [2:0] cfg_irc_freq, irc_freq_sel;
    logic [3:0] ctrl_wdata, ctrl_rdata;
    logic irc_clk, fast_xtal_clk, slow_rc_clk, slow_xtal_clk, config_error;
    logic core_run, periph_run, timer_run, fast_osc_en, slow_osc_en;
    logic timer0_slow_src, system_osc_clk, instruction_clk, fast_on, slow_on;
    logic pad_six_is_xin, pad_seven_is_xout, pad_gpio_free, pad_seven_inst_clk;
    logic [31:0] seed = 32'h1a;
    logic [31:0] wx, r;
    logic [31:0] eq[$];
    string nq[$];
    string wn;
    int n_fail = 0;
    int check_count = 0;
    int meas, p, i;
    logic trk = 1'b0;
    realtime last = 0, minw = 1.0e9;
    event smp;

    dcmc_osc_model u_dcmc_osc_model (.irc_clk, .fast_xtal_clk, .slow_rc_clk,
        .slow_xtal_clk);
    dcmc_top u_dcmc_top (.core_clk, .reset, .cfg_fast_src, .cfg_irc_freq,
        .cfg_slow_xtal, .cfg_startup_fast, .cfg_inst_div4, .cfg_inst_clk_out,
        .cfg_timer0_src, .irc_clk, .fast_xtal_clk, .slow_rc_clk, .slow_xtal_clk,
        .ctrl_we, .ctrl_wdata, .slow_clock_to_timer_select, .wake_timer,
        .wake_external, .wake_watchdog, .ctrl_rdata, .fast_clock_select, .mode,
        .irc_freq_sel, .config_error, .core_run, .periph_run, .timer_run,
        .fast_osc_en, .slow_osc_en, .timer0_slow_src, .system_osc_clk,
        .instruction_clk, .fast_on, .slow_on, .pad_six_is_xin,
        .pad_seven_is_xout, .pad_gpio_free, .pad_seven_inst_clk);

    always #25 core_clk = ~core_clk;

    // shortest pulse seen on the system clock
    always @(system_osc_clk)
    begin
        if (trk && $realtime - last < minw)
            minw = $realtime - last;
        last = $realtime;
    end

    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    function automatic logic [31:0] obs(string n);
        case (n)
            "mode": return {30'h0, mode};
            "sel": return {31'h0, fast_clock_select};
            "rdata": return {28'h0, ctrl_rdata};
            "err": return {31'h0, config_error};
            "freq": return {29'h0, irc_freq_sel};
            "xin": return {31'h0, pad_six_is_xin};
            "xout": return {31'h0, pad_seven_is_xout};
            "gpio": return {31'h0, pad_gpio_free};
            "iclk": return {31'h0, pad_seven_inst_clk};
            "t0": return {31'h0, timer0_slow_src};
            "core": return {31'h0, core_run};
            "timer": return {31'h0, timer_run};
            "slo": return {31'h0, slow_osc_en};
            "son": return {31'h0, slow_on};
            "fon": return {31'h0, fast_on};
            "fosc": return {31'h0, fast_osc_en};
            "per": return {31'h0, periph_run};
            "meas": return meas;
            "clean": return {31'h0, minw >= 29.0};
            default: return 32'hffffffff;
        endcase
    endfunction

    always @(smp)
    begin
        while (nq.size() > 0)
        begin
            wn = nq.pop_front();
            wx = eq.pop_front();
            `CHK(wn, wx, obs(wn))
        end
    end

    task automatic note(string n, logic [31:0] e);
        nq.push_back(n);
        eq.push_back(e);
    endtask

    task automatic fire(string t);
        -> smp;
        @(negedge core_clk);
        $display("test %s done", t);
    endtask

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    task automatic wr(logic [3:0] d);
        @(negedge core_clk);
        ctrl_we = 1'b1;
        ctrl_wdata = d;
        @(negedge core_clk);
        ctrl_we = 1'b0;
        @(negedge core_clk);
    endtask

    task automatic wfor(string n, logic [31:0] v, int lim);
        for (int k = 0; k < lim; k++)
        begin
            if (obs(n) === v)
                return;
            @(negedge core_clk);
        end
        n_fail++;
        $display("timeout waiting on %s", n);
        wrap_up();
    endtask

    task automatic rise(bit w, output realtime t);
        logic a, b;
        a = w ? instruction_clk : system_osc_clk;
        for (int k = 0; k < 100000; k++)
        begin
            #1;
            b = w ? instruction_clk : system_osc_clk;
            if (a === 1'b0 && b === 1'b1)
            begin
                t = $realtime;
                return;
            end
            a = b;
        end
        n_fail++;
        $display("timeout waiting on clock edge");
        wrap_up();
    endtask

    task automatic per(bit w);
        realtime a, b;
        rise(w, a);
        rise(w, b);
        meas = (int'(b - a) + 5) / 10;
    endtask

    task automatic do_reset(logic f);
        reset = 1'b1;
        cfg_startup_fast = f;
        repeat (16) @(negedge core_clk);
        reset = 1'b0;
        repeat (3) @(negedge core_clk);
    endtask

    initial
    begin
        {core_clk, cfg_slow_xtal, cfg_inst_div4, cfg_inst_clk_out} = 4'h0;
        {cfg_timer0_src, ctrl_we, slow_clock_to_timer_select} = 3'h0;
        {wake_timer, wake_external, wake_watchdog} = 3'h0;
        cfg_fast_src = 2'h0;
        cfg_irc_freq = 3'h0;
        ctrl_wdata = 4'h0;
        do_reset(1'b1);
        note("mode", 0);
        note("sel", 1);
        note("rdata", 32'h1);
        note("per", 1);
        note("fosc", 1);
        fire("startup");
        for (i = 0; i < 64; i++)
        begin
            r = xs();
            @(negedge core_clk);
            cfg_fast_src = i[1:0];
            cfg_slow_xtal = i[2];
            cfg_irc_freq = i[5:3];
            cfg_inst_clk_out = r[0];
            @(negedge core_clk);
            if (i[1:0] == 0 || i[5:3] < 6)
                note("err", i[1:0] == 3 || (i[1:0] != 0 && i[2]) ||
                    i[5:3] > 5);
            if (i[1:0] == 0 && i[5:3] < 6)
                note("freq", i[5:3]);
            if (i[1:0] != 3)
            begin
                note("xin", i[1:0] != 0 || i[2]);
                note("xout", i[1:0] != 0 || i[2]);
                note("gpio", i[1:0] == 0 && !i[2]);
                note("iclk", i[1:0] == 0 && !i[2] && r[0]);
            end
            -> smp;
            @(negedge core_clk);
        end
        $display("test pairings done");
        {cfg_fast_src, cfg_slow_xtal, cfg_irc_freq} = 6'h0;
        repeat (4) @(negedge core_clk);
        per(1'b0);
        note("meas", 6);
        note("slo", 1);
        fire("fast clock");
        for (i = 0; i < 2; i++)
        begin
            cfg_inst_div4 = i[0];
            repeat (4) @(negedge core_clk);
            per(1'b1);
            note("meas", i ? 24 : 12);
            fire("divider");
        end
        trk = 1'b1;
        wr(4'h0);
        note("mode", 1);
        note("rdata", 0);
        fire("to slow");
        wfor("son", 1, 5000);
        per(1'b0);
        note("meas", 3052);
        fire("slow clock");
        wr(4'he);
        note("mode", 1);
        note("rdata", 32'h2);
        note("fosc", 0);
        fire("stop fast");
        wr(4'h1);
        wfor("fon", 1, 5000);
        note("mode", 0);
        note("fosc", 1);
        note("clean", 1);
        fire("to normal");
        for (i = 0; i < 4; i++)
        begin
            @(negedge core_clk);
            slow_clock_to_timer_select = i[0];
            cfg_timer0_src = i[1];
            @(negedge core_clk);
            note("t0", i == 3);
            fire("timer source");
        end
        wr(4'h9);
        note("mode", 2);
        note("core", 0);
        note("timer", 1);
        note("per", 0);
        note("rdata", 32'h9);
        note("fosc", 1);
        fire("standby");
        wake_timer = 1'b1;
        wfor("mode", 0, 20);
        wake_timer = 1'b0;
        for (i = 0; i < 2; i++)
        begin
            wr(4'h5);
            note("mode", 3);
            note("timer", 0);
            note("rdata", 32'h5);
            note("slo", 0);
            note("fosc", 0);
            fire("halt");
            wake_timer = 1'b1;
            repeat (8) @(negedge core_clk);
            note("mode", 3);
            fire("halt holds");
            wake_timer = 1'b0;
            wake_watchdog = i[0];
            wake_external = !i[0];
            wfor("mode", 0, 20);
            {wake_watchdog, wake_external} = 2'h0;
        end
        trk = 1'b0;
        do_reset(1'b0);
        note("mode", 1);
        note("sel", 0);
        fire("slow startup");
        wrap_up();
    end
endmodule
`default_nettype wire
